// ===== hdl/rcs_pkg.sv
// ==========================================================
// reset sequencer constants
package rcs_pkg;
    // timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int POWERUP_DELAY_TIMER_TIME_MS    = 72;
    localparam int POWERUP_DELAY_TIMER_CYC        = POWERUP_DELAY_TIMER_TIME_MS * (CLK_HZ / 1000);
    localparam int BOR_MIN_TIME_US = 100;
    localparam int BOR_MIN_CYC     = BOR_MIN_TIME_US * (CLK_HZ / 1_000_000);
    localparam int OST_CYC         = 1024;
    localparam int POR_DLY_CYC     = 64;
    // configuration word fields
    localparam int         CFG_OSC_LSB = 0;
    localparam int         CFG_POWERUP_DELAY_TIMER_EN = 3;
    localparam int         CFG_BOR_EN  = 6;
    localparam int         CFG_PAR_EN  = 7;
    localparam logic [1:0] OSC_RC      = 2'h3;
    // apb register map
    localparam logic [11:0] ADDR_CAUSE  = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_SEQ    = 12'h008;
    // power_reset_cause fields
    localparam int         CAUSE_BOR = 0;
    localparam int         CAUSE_POR = 1;
    localparam int         CAUSE_PER = 2;
    localparam int         CAUSE_MIR = 7;
    localparam logic [2:0] CAUSE_RST = 3'h4;
    // status fields and watchdog_expiry/powerdown codes
    localparam int         ST_TOPD_LSB = 3;
    localparam logic [7:0] STATUS_RST  = 8'h18;
    localparam logic [1:0] TOPD_POR    = 2'h3;
    localparam logic [1:0] TOPD_WRST   = 2'h1;
    localparam logic [1:0] TOPD_WWAKE  = 2'h0;
    localparam logic [1:0] TOPD_SLEEP  = 2'h2;
    // program counter and sfr init values
    localparam logic [12:0] PC_RESET   = 13'h0000;
    localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
    localparam logic [7:0]  OPTION_INIT = 8'hff;
    localparam logic [7:0]  TRIS_INIT   = 8'hff;
    localparam logic [7:0]  INTCON_INIT = 8'h00;
    localparam logic [2:0]  PIN_RST     = 3'h4;

    typedef enum logic [2:0] {
        ST_POR_DLY  = 3'b000,
        ST_BOR_HOLD = 3'b001,
        ST_POWERUP_DELAY_TIMER     = 3'b010,
        ST_OST      = 3'b011,
        ST_WAIT_MC  = 3'b100,
        ST_RUN      = 3'b101,
        ST_SLEEP    = 3'b110,
        ST_WAKE_OST = 3'b111
    } rcs_state_type;

    typedef enum logic [2:0] {
        K_POR      = 3'b000,
        K_BOR      = 3'b001,
        K_MASTER_CLEAR_PIN_RUN = 3'b010,
        K_MASTER_CLEAR_PIN_SLP = 3'b011,
        K_WDT_RST  = 3'b100,
        K_WDT_WAKE = 3'b101,
        K_IRQ_WAKE = 3'b110,
        K_PARITY   = 3'b111
    } rcs_kind_type;
endpackage

// ===== hdl/rcs_tmr_if.sv
`timescale 1ns/1ps
// ==========================================================
// timer control bundle
interface rcs_tmr_if;
    logic clear;
    logic run;
    logic done;
    modport ctl (output clear, output run, input done);
    modport tmr (input clear, input run, output done);
endinterface

// ===== hdl/rcs_timer.sv
`timescale 1ns/1ps
// ==========================================================
// saturating delay counter, done after LIMIT run cycles
module rcs_timer #(
    parameter int LIMIT = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    rcs_tmr_if.tmr   t
);
    localparam int             W   = $clog2(LIMIT + 1);
    localparam logic [W-1:0]   LIM = W'(LIMIT);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // count up while running, hold at limit
    always_comb begin
        next_cnt = cnt;
        if (t.clear) begin
            next_cnt = '0;
        end else if (t.run && cnt != LIM) begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign t.done = (cnt == LIM);
endmodule

// ===== hdl/rcs_seq.sv
`timescale 1ns/1ps
module rcs_seq
    import rcs_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_CYCLES = rcs_pkg::POWERUP_DELAY_TIMER_CYC,
    parameter int BOR_CYCLES  = rcs_pkg::BOR_MIN_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        por_pulse,
    input  wire logic        brownout_low,
    input  wire logic        master_clear_n,
    // core side
    input  wire logic [13:0] cfg_word,
    input  wire logic        wdt_expire,
    input  wire logic        sleep_req,
    input  wire logic        irq_wake,
    input  wire logic        global_irq_enable,
    input  wire logic [12:0] pc_now,
    input  wire logic        fetch_valid,
    input  wire logic [13:0] fetch_word,
    input  wire logic [1:0]  fetch_parity,
    // sequencer outputs
    output logic             core_reset,
    output logic             core_halt,
    output logic             pc_load,
    output logic      [12:0] pc_value,
    output logic             sfr_init,
    output logic      [7:0]  option_init,
    output logic      [7:0]  tris_init,
    output logic      [7:0]  intcon_init
);
    import rcs_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [2:0] s1, s2, s3, pins;
    logic [2:0] next_pins;

    // a change counts once stages two and three agree
    always_comb begin
        next_pins = (s2 & s3) | (pins & (s2 | s3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1   <= PIN_RST;
            s2   <= PIN_RST;
            s3   <= PIN_RST;
            pins <= PIN_RST;
        end else begin
            s1   <= {master_clear_n, brownout_low, por_pulse};
            s2   <= s1;
            s3   <= s2;
            pins <= next_pins;
        end
    end

    logic por_lvl, low_lvl, master_clear_pin_low;
    assign por_lvl  = pins[0];
    assign low_lvl  = pins[1];
    assign master_clear_pin_low = !pins[2];

    // ==========================================================
    // configuration decode
    logic bor_en, powerup_delay_timer_en, par_en, xtal;
    assign bor_en  = cfg_word[CFG_BOR_EN];
    assign powerup_delay_timer_en = cfg_word[CFG_POWERUP_DELAY_TIMER_EN];
    assign par_en  = cfg_word[CFG_PAR_EN];
    assign xtal    = cfg_word[CFG_OSC_LSB +: 2] != OSC_RC;

    // ==========================================================
    // delay timers
    rcs_tmr_if por_t ();
    rcs_tmr_if powerup_delay_timer_t ();
    rcs_tmr_if ost_t ();
    rcs_tmr_if bor_t ();

    rcs_timer #(.LIMIT(POR_DLY_CYC)) u_por  (.pclk(pclk), .presetn(presetn), .t(por_t));
    rcs_timer #(.LIMIT(POWERUP_DELAY_TIMER_CYCLES)) u_powerup_delay_timer (.pclk(pclk), .presetn(presetn), .t(powerup_delay_timer_t));
    rcs_timer #(.LIMIT(OST_CYC))     u_ost  (.pclk(pclk), .presetn(presetn), .t(ost_t));
    rcs_timer #(.LIMIT(BOR_CYCLES))  u_bor  (.pclk(pclk), .presetn(presetn), .t(bor_t));

    rcs_state_type state, next_state;

    // timer run and clear from state, power-on timer also from the por pin, brown-out timer from bor_en and the low pin
    always_comb begin
        por_t.run    = (state == ST_POR_DLY) && !por_lvl;
        por_t.clear  = (state != ST_POR_DLY) || por_lvl;
        powerup_delay_timer_t.run   = (state == ST_POWERUP_DELAY_TIMER);
        powerup_delay_timer_t.clear = (state != ST_POWERUP_DELAY_TIMER);
        ost_t.run    = (state == ST_OST) || (state == ST_WAKE_OST);
        ost_t.clear  = !ost_t.run;
        bor_t.run    = bor_en && low_lvl;
        bor_t.clear  = !(bor_en && low_lvl);
    end

    // ==========================================================
    // fetch parity check
    logic [6:0] even_bits, odd_bits;
    logic       par_err;

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            even_bits[i] = fetch_word[2 * i];
            odd_bits[i]  = fetch_word[2 * i + 1];
        end
    end

    // even bit over even data, inverted odd bit over odd data
    assign par_err = par_en && fetch_valid &&
                     ((fetch_parity[0] ^ (^even_bits)) ||
                      (!fetch_parity[1] ^ (^odd_bits)));

    logic bor_evt;
    assign bor_evt = bor_t.done;

    // ==========================================================
    // sequencer and register state
    logic [2:0]    cause, next_cause;
    logic [7:0]    status, next_status;
    logic [12:0]   pc_tgt, next_pc_tgt;
    rcs_kind_type  kind, next_kind;
    logic          evt;
    rcs_kind_type  evt_kind;
    logic          next_pc_load, next_sfr_init;
    logic [31:0]   next_prdata, rd_word;
    logic          wr_en, mapped;

    // after the power-on delay or brown-out hold, where to go
    function automatic rcs_state_type after_delay(input logic pw, input logic xt);
        if (pw) begin
            after_delay = ST_POWERUP_DELAY_TIMER;
        end else if (xt) begin
            after_delay = ST_OST;
        end else begin
            after_delay = ST_WAIT_MC;
        end
    endfunction

    // reset event detection, highest priority first
    always_comb begin
        evt      = 1'b0;
        evt_kind = K_POR;
        if (por_lvl) begin
            evt = 1'b1;
        end else if (bor_evt) begin
            evt      = 1'b1;
            evt_kind = K_BOR;
        end else if (state == ST_RUN) begin
            evt = master_clear_pin_low || wdt_expire || par_err;
            if (master_clear_pin_low) begin
                evt_kind = K_MASTER_CLEAR_PIN_RUN;
            end else if (wdt_expire) begin
                evt_kind = K_WDT_RST;
            end else begin
                evt_kind = K_PARITY;
            end
        end else if (state == ST_SLEEP || state == ST_WAKE_OST) begin
            evt = master_clear_pin_low || (state == ST_SLEEP && (wdt_expire || irq_wake));
            if (master_clear_pin_low) begin
                evt_kind = K_MASTER_CLEAR_PIN_SLP;
            end else if (wdt_expire) begin
                evt_kind = K_WDT_WAKE;
            end else begin
                evt_kind = K_IRQ_WAKE;
            end
        end
    end

    // apb decode
    assign mapped = (paddr == ADDR_CAUSE) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_SEQ);
    assign wr_en  = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // read mux, bit 7 of cause mirrors the configuration
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            ADDR_CAUSE: begin
                rd_word[CAUSE_MIR] = par_en;
                rd_word[2:0]       = cause;
            end
            ADDR_STATUS: rd_word[7:0] = status;
            ADDR_SEQ:    rd_word[7:0] = {1'b0, kind, 1'b0, state};
            default:     rd_word = 32'h0000_0000;
        endcase
    end

    // next values of all control state
    always_comb begin
        next_state    = state;
        next_cause    = cause;
        next_status   = status;
        next_pc_tgt   = pc_tgt;
        next_kind     = kind;
        next_pc_load  = 1'b0;
        next_sfr_init = 1'b0;
        next_prdata   = (psel && !penable) ? rd_word : prdata;
        // software writes, hardware events below win
        if (wr_en && paddr == ADDR_CAUSE) begin
            next_cause = pwdata[2:0];
        end
        if (wr_en && paddr == ADDR_STATUS) begin
            next_status = {pwdata[7:5], status[4:3], pwdata[2:0]};
        end
        // sequence steps
        case (state)
            ST_POR_DLY: begin
                if (por_t.done) begin
                    next_state = after_delay(powerup_delay_timer_en, xtal);
                end
            end
            ST_BOR_HOLD: begin
                if (!low_lvl) begin
                    next_state = after_delay(powerup_delay_timer_en, xtal);
                end
            end
            ST_POWERUP_DELAY_TIMER: begin
                if (powerup_delay_timer_t.done) begin
                    next_state = xtal ? ST_OST : ST_WAIT_MC;
                end
            end
            ST_OST: begin
                if (ost_t.done) begin
                    next_state = ST_WAIT_MC;
                end
            end
            ST_WAIT_MC: begin
                if (!master_clear_pin_low) begin
                    next_state   = ST_RUN;
                    next_pc_load = 1'b1;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                next_state = ST_SLEEP;
            end
            ST_WAKE_OST: begin
                if (ost_t.done) begin
                    next_state   = ST_RUN;
                    next_pc_load = 1'b1;
                end
            end
            default: next_state = ST_POR_DLY;
        endcase
        // reset and wake events
        if (evt) begin
            next_kind   = evt_kind;
            next_pc_tgt = PC_RESET;
            case (evt_kind)
                K_POR: begin
                    next_state            = ST_POR_DLY;
                    next_cause[CAUSE_POR] = 1'b0;
                    next_cause[CAUSE_PER] = 1'b1;
                    next_status = {3'h0, TOPD_POR, status[2:0]};
                end
                K_BOR: begin
                    next_state            = ST_BOR_HOLD;
                    next_cause[CAUSE_BOR] = 1'b0;
                    next_cause[CAUSE_PER] = 1'b1;
                    next_cause[CAUSE_POR] = cause[CAUSE_POR];
                    next_status = {3'h0, TOPD_POR, status[2:0]};
                end
                K_MASTER_CLEAR_PIN_RUN: begin
                    next_state  = ST_WAIT_MC;
                    next_status = {3'h0, status[4:0]};
                end
                K_MASTER_CLEAR_PIN_SLP: begin
                    next_state  = ST_WAIT_MC;
                    next_status = {3'h0, TOPD_SLEEP, status[2:0]};
                end
                K_WDT_RST: begin
                    next_state  = ST_WAIT_MC;
                    next_status = {3'h0, TOPD_WRST, status[2:0]};
                end
                K_PARITY: begin
                    next_state            = ST_WAIT_MC;
                    next_cause[CAUSE_PER] = 1'b0;
                    next_status = {status[7:5], TOPD_SLEEP, status[2:0]};
                end
                K_WDT_WAKE, K_IRQ_WAKE: begin
                    next_state  = xtal ? ST_WAKE_OST : ST_RUN;
                    next_pc_load = !xtal;
                    next_pc_tgt = pc_now + 13'h0001;
                    if (evt_kind == K_IRQ_WAKE && global_irq_enable) begin
                        next_pc_tgt = PC_IRQ_VEC;
                    end
                    next_status = {status[7:5],
                                   (evt_kind == K_IRQ_WAKE) ? TOPD_SLEEP : TOPD_WWAKE,
                                   status[2:0]};
                end
                default: next_state = ST_WAIT_MC;
            endcase
            // wake-ups leave special registers alone
            next_sfr_init = evt_kind != K_WDT_WAKE && evt_kind != K_IRQ_WAKE &&
                            evt_kind != K_PARITY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_POR_DLY;
            cause       <= CAUSE_RST;
            status      <= STATUS_RST;
            pc_tgt      <= PC_RESET;
            kind        <= K_POR;
            prdata      <= 32'h0000_0000;
            core_reset  <= 1'b1;
            core_halt   <= 1'b0;
            pc_load     <= 1'b0;
            pc_value    <= PC_RESET;
            sfr_init    <= 1'b1;
        end else begin
            state       <= next_state;
            cause       <= next_cause;
            status      <= next_status;
            pc_tgt      <= next_pc_tgt;
            kind        <= next_kind;
            prdata      <= next_prdata;
            core_reset  <= !(next_state inside {ST_RUN, ST_SLEEP, ST_WAKE_OST});
            core_halt   <= next_state inside {ST_SLEEP, ST_WAKE_OST};
            pc_load     <= next_pc_load;
            pc_value    <= next_pc_load ? next_pc_tgt : pc_value;
            sfr_init    <= next_sfr_init;
        end
    end

    // fixed initial images for the core's special registers
    assign option_init = OPTION_INIT;
    assign tris_init   = TRIS_INIT;
    assign intcon_init = INTCON_INIT;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_powerup_delay_timer_done;
        state == ST_POWERUP_DELAY_TIMER && powerup_delay_timer_t.done;
    endsequence

    sequence s_after_powerup_delay_timer;
        ##1 state == (xtal ? ST_OST : ST_WAIT_MC);
    endsequence

    bor_gate_a: assert property (!bor_en |-> !bor_evt)
        else $error("brown-out event with detection disabled");
    bor_hold_a: assert property (state == ST_BOR_HOLD |-> core_reset)
        else $error("reset released during brown-out hold");
    bor_restart_a: assert property (
        state == ST_POWERUP_DELAY_TIMER && bor_evt && !por_lvl |=> state == ST_BOR_HOLD ##1 !powerup_delay_timer_t.done)
        else $error("brown-out dip did not restart delay");
    powerup_delay_timer_order_a: assert property ((s_powerup_delay_timer_done and !evt) |-> s_after_powerup_delay_timer)
        else $error("start-up timer order broken");
    rc_nodelay_a: assert property (
        state == ST_POR_DLY && por_t.done && !por_lvl && !bor_evt && !powerup_delay_timer_en && !xtal
        |=> state == ST_WAIT_MC)
        else $error("rc mode applied a time-out");
    master_clear_pin_go_a: assert property (
        state == ST_WAIT_MC && !master_clear_pin_low && !evt |=> state == ST_RUN && !core_reset && pc_load)
        else $error("pin release did not start execution");
    par_rst_a: assert property (state == ST_RUN && par_err && !por_lvl &&
        !bor_evt && !master_clear_pin_low && !wdt_expire |=> !cause[CAUSE_PER] && state == ST_WAIT_MC)
        else $error("parity error not handled");
    por_flags_a: assert property (por_lvl |=>
        status[ST_TOPD_LSB +: 2] == TOPD_POR && !cause[CAUSE_POR] && cause[CAUSE_PER])
        else $error("power-on flags wrong");
    irq_vec_a: assert property (state == ST_SLEEP && !evt_kind[0] && evt &&
        evt_kind == K_IRQ_WAKE && global_irq_enable && !xtal |=> ##1 pc_value == PC_IRQ_VEC)
        else $error("interrupt wake missed vector");
endmodule

// ===== test/reset_cause_and_timeout_seq_test.sv
`timescale 1ns/1ps
module reset_cause_and_timeout_seq_test;
    import rcs_pkg::*;
    localparam int POWERUP_DELAY_TIMER_N = 200;
    localparam int BOR_N  = 20;
    // ==========================================
    // stimulus and observation
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic        pready, pslverr, e, seen;
    logic        por_pulse = 0, brownout_low = 0, master_clear_n = 1;
    logic [13:0] cfg_word = 14'h00c8; // delay timer on with brown-out on
    logic        wdt_expire = 0, sleep_req = 0, irq_wake = 0, global_irq_enable = 0;
    logic        fetch_valid = 0;
    logic [13:0] fetch_word = 0;
    logic [1:0]  fetch_parity = 2'h2;
    logic        core_reset, core_halt, pc_load, sfr_init;
    logic [12:0] pc_value;
    logic [7:0]  option_init, tris_init, intcon_init;
    int          err_count = 0, n_tests = 0, c;
    // 50 mhz clock
    always #10 pclk = ~pclk;
    rcs_seq #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_N), .BOR_CYCLES(BOR_N)) dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_pulse(por_pulse),
        .brownout_low(brownout_low), .master_clear_n(master_clear_n), .cfg_word(cfg_word),
        .wdt_expire(wdt_expire), .sleep_req(sleep_req), .irq_wake(irq_wake),
        .global_irq_enable(global_irq_enable), .pc_now(13'h0100), .fetch_valid(fetch_valid),
        .fetch_word(fetch_word), .fetch_parity(fetch_parity), .core_reset(core_reset),
        .core_halt(core_halt), .pc_load(pc_load), .pc_value(pc_value), .sfr_init(sfr_init),
        .option_init(option_init), .tris_init(tris_init), .intcon_init(intcon_init));
    // ==========================================
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, waits for pready, result in q and e
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // wait for core_reset (pick 0) or pc_load (pick 1) at level lvl
    task wait_for(input logic pick, input logic lvl, output int cnt);
        cnt = 0;
        do begin
            @(negedge pclk);
            cnt++;
            if (sfr_init === 1'b1) seen = 1;
        end while (((pick ? pc_load : core_reset) !== lvl) && cnt < 5000);
        if (cnt >= 5000) chk(32'h1, 32'h0);
    endtask
    task step(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task summarize;
        $display("counts: %0d mismatches in %0d compares", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        step(4);
        presetn <= 1;
        wait_for(0, 0, c);
        chk(32'(c >= POR_DLY_CYC + POWERUP_DELAY_TIMER_N + OST_CYC), 1);
        chk(32'({pc_load, pc_value}), 32'({1'b1, PC_RESET}));
        apb(0, ADDR_CAUSE, 0);
        chk(q & 32'h86, 32'h84);
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[4:3]), 32'(TOPD_POR));
        apb(1, ADDR_CAUSE, 32'h07);
        apb(0, ADDR_CAUSE, 0);
        chk(32'(q[7:0]), 32'h87);
        apb(0, 12'h00c, 0);
        chk({q[30:0], e}, 32'h1);
        $display("test power-up done");
        // short dip ignored, long dip with re-dip in delay timer
        brownout_low <= 1; step(5); brownout_low <= 0; step(10);
        chk(32'(core_reset), 0);
        brownout_low <= 1; step(BOR_N + 10); brownout_low <= 0; step(50);
        chk(32'(core_reset), 1);
        brownout_low <= 1; step(BOR_N + 10); brownout_low <= 0;
        wait_for(0, 0, c);
        chk(32'(c >= POWERUP_DELAY_TIMER_N + OST_CYC), 1);
        apb(0, ADDR_CAUSE, 0);
        chk(32'(q[2:0]), 32'h6);
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[4:3]), 32'(TOPD_POR));
        $display("test brown-out done");
        // watchdog reset loads sfr defaults
        seen = 0; wdt_expire <= 1; step(1); wdt_expire <= 0;
        wait_for(0, 1, c); wait_for(0, 0, c);
        chk(32'({seen, pc_load, option_init, intcon_init}), 32'h3ff00);
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[4:3]), 32'(TOPD_WRST));
        $display("test watchdog done");
        // good word passes, bad word resets
        apb(1, ADDR_CAUSE, 32'h07);
        fetch_parity <= 2'h1;
        fetch_valid <= 1; fetch_word <= 14'h0003; step(1);
        fetch_valid <= 0; step(5);
        chk(32'(core_reset), 0);
        fetch_valid <= 1; fetch_parity <= 2'h0; step(1); fetch_valid <= 0;
        wait_for(0, 1, c); wait_for(0, 0, c);
        apb(0, ADDR_CAUSE, 0);
        chk(32'(q[2:0]), 32'h3);
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[4:3]), 32'(TOPD_SLEEP));
        $display("test parity done");
        // sleep then interrupt wake with vector
        sleep_req <= 1; step(1); sleep_req <= 0; step(5);
        chk(32'(core_halt), 1);
        seen = 0; global_irq_enable <= 1; irq_wake <= 1;
        step(1);
        irq_wake <= 0;
        wait_for(1, 1, c);
        chk(32'({seen, pc_value}), 32'(PC_IRQ_VEC));
        chk(32'(c >= OST_CYC), 1);
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[4:3]), 32'(TOPD_SLEEP));
        $display("test wake done");
        // time-outs expire under a held pin
        por_pulse <= 1; master_clear_n <= 0; step(8); por_pulse <= 0;
        step(POR_DLY_CYC + POWERUP_DELAY_TIMER_N + OST_CYC + 20);
        chk(32'(core_reset), 1);
        master_clear_n <= 1;
        wait_for(0, 0, c);
        chk(32'(c <= 8), 1);
        apb(0, ADDR_CAUSE, 0);
        chk(32'(q[2:1]), 32'h2);
        $display("test held pin done");
        // rc mode without delay timer: no time-out, no start-up wait on wake
        cfg_word <= 14'h0083; // brown-out off with the delay timer off
        presetn <= 0;
        step(4);
        presetn <= 1;
        wait_for(0, 0, c);
        chk(32'(c <= POR_DLY_CYC + 8), 1);
        step(1);
        sleep_req <= 1;
        step(1);
        sleep_req <= 0;
        irq_wake <= 1;
        step(1);
        irq_wake <= 0;
        wait_for(1, 1, c);
        chk(32'({c <= 4, pc_value}), 32'({1'b1, PC_IRQ_VEC}));
        step(1);
        sleep_req <= 1;
        step(1);
        sleep_req <= 0;
        wdt_expire <= 1;
        step(1);
        wdt_expire <= 0;
        wait_for(1, 1, c);
        chk(32'(pc_value), 32'h0000_0101); // pc_now is tied to 100h
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[4:3]), 32'(TOPD_WWAKE));
        // master clear while running, then while asleep
        seen = 0;
        master_clear_n <= 0;
        wait_for(0, 1, c);
        step(1);
        master_clear_n <= 1;
        wait_for(0, 0, c);
        chk(32'({seen, pc_load, pc_value}), 32'({2'h3, PC_RESET}));
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[7:3]), 32'({3'h0, TOPD_WWAKE}));
        sleep_req <= 1;
        step(1);
        sleep_req <= 0;
        master_clear_n <= 0;
        wait_for(0, 1, c);
        step(1);
        master_clear_n <= 1;
        wait_for(0, 0, c);
        apb(0, ADDR_STATUS, 0);
        chk(32'(q[4:3]), 32'(TOPD_SLEEP));
        $display("test rc mode done");
        summarize();
    end
    // hang guard
    initial begin
        #400000;
        err_count++;
        summarize();
    end
endmodule
